// ===== design/mdu_pkg.sv
// mdu_pkg: shared types and constants of the multiply/divide unit
// assumes: single 100 MHz core clock, synchronous active-high reset
package mdu_pkg;

  localparam int unsigned DATA_W      = 32;
  localparam int unsigned HALF_W      = 16;
  localparam int unsigned CYC_PRD_NS  = 10;
  // divide iterations skipped for 8, 16 and 24 bit dividends
  localparam logic [5:0]  SKIP_8      = 6'h17;
  localparam logic [5:0]  SKIP_16     = 6'h0F;
  localparam logic [5:0]  SKIP_24     = 6'h07;
  localparam logic [5:0]  DIV_ITERS   = 6'h20;
  // extra cycles of the divide beyond its iterations (latency 33 = 32 + 1)
  localparam logic [5:0]  DIV_TAIL    = 6'h01;
  localparam logic [1:0]  MUL_PASS_1  = 2'h1;
  localparam logic [1:0]  MUL_PASS_2  = 2'h2;

  typedef enum logic [2:0] {
    MDU_OP_NONE,
    MDU_OP_MULT,
    MDU_OP_MADD,
    MDU_OP_MSUB,
    MDU_OP_MULGPR,
    MDU_OP_DIV
  } mdu_op_type;

  typedef struct packed {
    mdu_op_type        op;
    logic              is_signed;
    logic [4:0]        dest;
    logic [DATA_W-1:0] first_source_operand;
    logic [DATA_W-1:0] second_source_operand;
  } mdu_req_type;

  typedef struct packed {
    logic              valid;
    logic [4:0]        dest;
    logic [DATA_W-1:0] data;
  } mdu_gpr_type;

endpackage : mdu_pkg

// ===== design/mdu_booth.sv
// mdu_booth: one pass of a radix-4 booth recoded 32x16 multiplier
// assumes: combinational; caller shifts and accumulates passes
`timescale 1ns/1ns
`default_nettype none
module mdu_booth
  import mdu_pkg::*;
(
  input  wire logic [DATA_W:0]        mcand,
  input  wire logic [HALF_W:0]        mplier,
  output logic      [DATA_W+HALF_W:0] product
);
  localparam int unsigned PW = DATA_W + HALF_W + 1;

  always_comb begin
    logic signed [PW-1:0] acc;
    logic signed [PW-1:0] ext;
    logic [2:0]           grp;
    acc = '0;
    grp = 3'h0;
    ext = PW'(signed'(mcand));
    for (int i = 0; i < HALF_W / 2 + 1; i++) begin
      grp = {(2*i+1 <= HALF_W) ? mplier[2*i+1] : mplier[HALF_W],
             (2*i <= HALF_W) ? mplier[2*i] : mplier[HALF_W],
             (i == 0) ? 1'b0 : mplier[2*i-1]};
      unique case (grp)
        3'h1, 3'h2: acc = acc + (ext <<< (2*i));
        3'h3:       acc = acc + (ext <<< (2*i+1));
        3'h4:       acc = acc - (ext <<< (2*i+1));
        3'h5, 3'h6: acc = acc - (ext <<< (2*i));
        default:    acc = acc;
      endcase
    end
    product = acc;
  end
endmodule : mdu_booth
`default_nettype wire

// ===== design/mdu_unit.sv
// mdu_unit: multiply/divide unit beside the integer pipeline
// assumes: issuer holds req_valid and request while stall is high
//
// Operation
// - own pipeline keeps advancing while the integer pipeline stalls
// - 32x16 booth multiplier, divide machine, upper/bottom result pair
// - pass count set by second operand only; 16-bit fits take one pass
// - 32x16 multiply every cycle, 32x32 every second cycle
// - back-to-back 32x32 multiplies raise stall; issuer holds the op
// - divide resolves one quotient bit per clock
// - skip 23, 15 or 7 iterations for 8, 16, 24 bit dividends
// - any op during an active divide stalls until it finishes
// - result-pair multiplies: latency/repeat 1 short, 2 long operand
// - general-register multiply: latency 2/3, repeat 1/2
// - divide latency 10/18/26/33, repeat 11/19/27/34
`timescale 1ns/1ns
`default_nettype none
module mdu_unit
  import mdu_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               req_valid,
  input  wire mdu_req_type        req,
  input  wire logic               pipe_stall,
  output logic                    stall,
  output logic      [DATA_W-1:0]  result_upper_word,
  output logic      [DATA_W-1:0]  result_bottom_word,
  output mdu_gpr_type             gpr_wb,
  output logic                    div_busy
);
  localparam int unsigned PW = DATA_W + HALF_W + 1;

  // pass bookkeeping
  logic              pass2_reg;
  logic              mul_long_reg;
  mdu_op_type        mop_reg;
  logic [4:0]        mdest_reg;
  logic              msgn_reg;
  logic [DATA_W:0]   mcand_reg;
  logic [HALF_W:0]   mhi_reg;
  logic [2*DATA_W-1:0] part_reg;
  logic              gpr_pend_reg;
  logic [4:0]        gpr_dest_reg;
  logic [DATA_W-1:0] gpr_data_reg;
  // divide state
  logic [5:0]        div_cnt_reg;
  logic [DATA_W-1:0] dvd_reg;
  logic [DATA_W-1:0] dvs_reg;
  logic [DATA_W-1:0] rem_reg;
  logic              qneg_reg;
  logic              rneg_reg;

  logic [DATA_W:0]         booth_a;
  logic [HALF_W:0]         booth_b;
  logic [PW-1:0]           booth_p;
  logic                    is_mul;
  logic                    is_long;
  logic                    take;
  logic [2*DATA_W-1:0]     prod_full;
  logic [2*DATA_W-1:0]     acc_cur;

  function automatic logic fits_signed(input logic [DATA_W-1:0] v,
                                       input int unsigned w,
                                       input logic sg);
    logic [DATA_W-1:0] top;
    top = v >> (w - 1);
    if (sg)
      return (top == '0) || (top == {DATA_W{1'b1}} >> (w - 1));
    return (v >> w) == '0;
  endfunction : fits_signed

  function automatic logic [DATA_W-1:0] mag(input logic [DATA_W-1:0] v,
                                            input logic sg);
    return (sg && v[DATA_W-1]) ? DATA_W'(-v) : v;
  endfunction : mag

  assign is_mul  = req.op inside {MDU_OP_MULT, MDU_OP_MADD,
                                  MDU_OP_MSUB, MDU_OP_MULGPR};
  // operand size taken from the second operand only
  assign is_long = !fits_signed(req.second_source_operand, HALF_W,
                                req.is_signed);

  // interlock: long multiply in flight or divide active
  always_comb begin
    stall = 1'b0;
    if (req_valid && div_cnt_reg != '0)
      stall = 1'b1;
    else if (req_valid && pass2_reg)
      stall = 1'b1;
  end

  // pipeline ignores pipe_stall and keeps running
  assign take = req_valid && !stall;

  // first pass uses the low half, second the high half
  always_comb begin
    if (pass2_reg) begin
      booth_a = mcand_reg;
      booth_b = mhi_reg;
    end else begin
      booth_a = {req.is_signed & req.first_source_operand[DATA_W-1],
                 req.first_source_operand};
      booth_b = (is_long || !req.is_signed)
                  ? {1'b0, req.second_source_operand[HALF_W-1:0]}
                  : {req.second_source_operand[HALF_W-1],
                     req.second_source_operand[HALF_W-1:0]};
    end
  end

  mdu_booth u_booth (
    .mcand   (booth_a),
    .mplier  (booth_b),
    .product (booth_p)
  );

  always_comb begin
    prod_full = (2*DATA_W)'(signed'(booth_p));
    if (pass2_reg)
      prod_full = part_reg + (prod_full << HALF_W);
    acc_cur = {result_upper_word, result_bottom_word};
  end

  // multiply sequencing, one or two passes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pass2_reg    <= 1'b0;
      mul_long_reg <= 1'b0;
      mop_reg      <= MDU_OP_NONE;
      mdest_reg    <= '0;
      msgn_reg     <= 1'b0;
      mcand_reg    <= '0;
      mhi_reg      <= '0;
      part_reg     <= '0;
    end else begin
      pass2_reg <= take && is_mul && is_long;
      if (take && is_mul) begin
        mul_long_reg <= is_long;
        mop_reg      <= req.op;
        mdest_reg    <= req.dest;
        msgn_reg     <= req.is_signed;
        mcand_reg    <= booth_a;
        mhi_reg      <= {req.is_signed & req.second_source_operand[DATA_W-1],
                         req.second_source_operand[DATA_W-1:HALF_W]};
        part_reg     <= prod_full;
      end
    end
  end

  // commit of a finishing multiply or divide into the pair
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      result_upper_word  <= '0;
      result_bottom_word <= '0;
    end else if (div_cnt_reg == DIV_TAIL) begin
      result_bottom_word <= qneg_reg ? DATA_W'(-dvd_reg) : dvd_reg;
      result_upper_word  <= rneg_reg ? DATA_W'(-rem_reg) : rem_reg;
    end else if ((take && is_mul && !is_long) || pass2_reg) begin
      unique case (pass2_reg ? mop_reg : req.op)
        MDU_OP_MADD: {result_upper_word, result_bottom_word} <=
                       acc_cur + prod_full;
        MDU_OP_MSUB: {result_upper_word, result_bottom_word} <=
                       acc_cur - prod_full;
        MDU_OP_MULGPR: ;
        default:     {result_upper_word, result_bottom_word} <= prod_full;
      endcase
    end
  end

  // general register result one stage later
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gpr_pend_reg <= 1'b0;
      gpr_dest_reg <= '0;
      gpr_data_reg <= '0;
      gpr_wb       <= '0;
    end else begin
      gpr_pend_reg <= 1'b0;
      if (pass2_reg && mop_reg == MDU_OP_MULGPR) begin
        gpr_pend_reg <= 1'b1;
        gpr_dest_reg <= mdest_reg;
        gpr_data_reg <= prod_full[DATA_W-1:0];
      end else if (take && req.op == MDU_OP_MULGPR && !is_long) begin
        gpr_pend_reg <= 1'b1;
        gpr_dest_reg <= req.dest;
        gpr_data_reg <= prod_full[DATA_W-1:0];
      end
      gpr_wb.valid <= gpr_pend_reg;
      gpr_wb.dest  <= gpr_dest_reg;
      gpr_wb.data  <= gpr_data_reg;
    end
  end

  // restoring divide, one quotient bit each clock
  always_ff @(posedge sys_clk) begin
    logic [DATA_W-1:0] a;
    logic [DATA_W:0]   trial;
    logic [5:0]        skip;
    if (sys_rst) begin
      div_cnt_reg <= '0;
      dvd_reg     <= '0;
      dvs_reg     <= '0;
      rem_reg     <= '0;
      qneg_reg    <= 1'b0;
      rneg_reg    <= 1'b0;
      div_busy    <= 1'b0;
    end else begin
      if (take && req.op == MDU_OP_DIV) begin
        a = mag(req.first_source_operand, req.is_signed);
        // early-in on the dividend width
        if (fits_signed(req.first_source_operand, 8, req.is_signed))
          skip = SKIP_8;
        else if (fits_signed(req.first_source_operand, HALF_W,
                             req.is_signed))
          skip = SKIP_16;
        else if (fits_signed(req.first_source_operand, 24, req.is_signed))
          skip = SKIP_24;
        else
          skip = '0;
        dvd_reg     <= a << skip;
        rem_reg     <= '0;
        dvs_reg     <= mag(req.second_source_operand, req.is_signed);
        qneg_reg    <= req.is_signed && (req.first_source_operand[DATA_W-1]
                       ^ req.second_source_operand[DATA_W-1]);
        rneg_reg    <= req.is_signed && req.first_source_operand[DATA_W-1];
        div_cnt_reg <= DIV_ITERS - skip + DIV_TAIL;
        div_busy    <= 1'b1;
      end else if (div_cnt_reg > DIV_TAIL) begin
        trial = {rem_reg, dvd_reg[DATA_W-1]} - {1'b0, dvs_reg};
        if (!trial[DATA_W]) begin
          rem_reg <= trial[DATA_W-1:0];
          dvd_reg <= {dvd_reg[DATA_W-2:0], 1'b1};
        end else begin
          rem_reg <= {rem_reg[DATA_W-2:0], dvd_reg[DATA_W-1]};
          dvd_reg <= {dvd_reg[DATA_W-2:0], 1'b0};
        end
        div_cnt_reg <= div_cnt_reg - 6'h01;
      end else if (div_cnt_reg == DIV_TAIL) begin
        div_cnt_reg <= '0;
        div_busy    <= 1'b0;
      end
    end
  end

endmodule : mdu_unit
`default_nettype wire

// ===== testbench/mdu_tb_pkg.sv
// mdu_tb_pkg: reference arithmetic for bench and checker
// assumes: 32-bit operands
`default_nettype none
package mdu_tb_pkg;
  function automatic logic [63:0] mul64(logic [31:0] a, b, logic s);
    return s ? {{32{a[31]}}, a} * {{32{b[31]}}, b} : {32'h0, a} * {32'h0, b};
  endfunction : mul64
  function automatic logic fits16(logic [31:0] b, logic s);
    return s ? (&b[31:15] || ~|b[31:15]) : ~|b[31:16];
  endfunction : fits16
endpackage : mdu_tb_pkg
`default_nettype wire

// ===== testbench/mdu_monitor.sv
// mdu_monitor: concurrent checks on the unit's ports
// assumes: bound to mdu_unit, one clock, sync reset
`timescale 1ns/1ns
`default_nettype none
module mdu_monitor
  import mdu_pkg::*, mdu_tb_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire logic              req_valid,
  input wire mdu_req_type       req,
  input wire logic              pipe_stall,
  input wire logic              stall,
  input wire logic [DATA_W-1:0] result_upper_word,
  input wire logic [DATA_W-1:0] result_bottom_word,
  input wire mdu_gpr_type       gpr_wb,
  input wire logic              div_busy
);
  logic        tk;
  logic        sh;
  logic [63:0] pr;
  logic [63:0] pair;
  logic        lp_reg;
  logic [6:0]  cnt_reg;
  logic [6:0]  exp_reg;
  function automatic logic [6:0] iters(logic [31:0] a, logic s);
    logic [31:0] t;
    iters = 7'h20;
    for (int w = 24; w >= 8; w -= 8) begin
      t = s ? 32'($signed(a) >>> (w - 1)) : a >> w;
      if (t == 32'h0 || (s && t == 32'hFFFFFFFF)) iters = 7'(w + 1);
    end
  endfunction : iters
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  assign tk = req_valid && !stall;
  assign sh = fits16(req.second_source_operand, req.is_signed);
  assign pr = mul64(req.first_source_operand, req.second_source_operand,
                    req.is_signed);
  assign pair = {result_upper_word, result_bottom_word};
  always_ff @(posedge sys_clk) begin
    lp_reg <= !sys_rst && tk && !sh && req.op != MDU_OP_DIV;
  end
  always_ff @(posedge sys_clk) begin
    cnt_reg <= (sys_rst || !div_busy) ? 7'h0 : cnt_reg + 7'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (tk && req.op == MDU_OP_DIV) begin
      exp_reg <= iters(req.first_source_operand, req.is_signed);
    end
  end
  stall_idle_a: assert property (!req_valid |-> !stall)
    else $error("stall with no request");
  div_stall_a: assert property (req_valid && div_busy |-> stall)
    else $error("no stall during divide");
  short_issue_a: assert property (req_valid && !div_busy && !lp_reg |-> !stall)
    else $error("needless stall");
  long_block_a: assert property (lp_reg && req_valid |-> stall)
    else $error("no stall after long multiply");
  div_length_a: assert property ($fell(div_busy) |->
    cnt_reg >= exp_reg && cnt_reg <= exp_reg + 7'h2)
    else $error("divide length wrong");
  pair_short_a: assert property (tk && req.op == MDU_OP_MULT && sh |=>
    pair == $past(pr)) else $error("short product wrong");
  pair_long_a: assert property (tk && req.op == MDU_OP_MULT && !sh |->
    ##2 pair == $past(pr, 2)) else $error("long product wrong");
  gpr_short_a: assert property (tk && req.op == MDU_OP_MULGPR && sh |->
    ##2 gpr_wb.valid && gpr_wb.data == 32'($past(pr, 2)))
    else $error("register product wrong");
  cover property (lp_reg && req_valid);
  cover property ($fell(div_busy));
  cover property (gpr_wb.valid && pipe_stall);
endmodule : mdu_monitor
`default_nettype wire

// ===== testbench/mdu_issuer.sv
// mdu_issuer: integer pipeline model issuing operations
// assumes: tasks entered 1 ns after a rising edge
`timescale 1ns/1ns
`default_nettype none
module mdu_issuer
  import mdu_pkg::*;
(
  input wire logic     sys_clk,
  input wire logic     stall,
  output var logic     req_valid,
  output var mdu_req_type req
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  task automatic issue(mdu_req_type r, output int waits);
    waits = 0;
    req_valid = 1'b1;
    req = r;
    #1;
    while (stall === 1'b1) begin
      @(posedge sys_clk);
      #2;
      waits++;
    end
    @(posedge sys_clk);
    #1;
  endtask : issue
  task automatic drop_req();
    req_valid = 1'b0;
    req = ~req;
  endtask : drop_req
endmodule : mdu_issuer
`default_nettype wire

// ===== testbench/testbench.sv
// testbench: random and corner runs of the multiply/divide unit
// assumes: mdu_issuer plays the integer pipeline
`timescale 1ns/1ns
`default_nettype none
module testbench
  import mdu_pkg::*, mdu_tb_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pipe_stall = 1'b0;
  logic req_valid;
  logic stall;
  logic div_busy;
  logic [DATA_W-1:0] upper;
  logic [DATA_W-1:0] bottom;
  mdu_req_type req;
  mdu_gpr_type gpr_wb;
  logic [63:0] acc;
  logic acc_ok;
  int w;
  int n_fail = 0;
  int n_checks = 0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) pipe_stall <= #1 1'($urandom);
  mdu_unit uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req(req), .pipe_stall(pipe_stall), .stall(stall),
    .result_upper_word(upper), .result_bottom_word(bottom),
    .gpr_wb(gpr_wb), .div_busy(div_busy));
  mdu_issuer u_iss (.sys_clk(sys_clk), .stall(stall),
    .req_valid(req_valid), .req(req));
  task automatic check(logic [63:0] got, logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  function automatic logic [31:0] rnd(logic s);
    logic [31:0] v;
    int k;
    v = $urandom;
    k = 8 * $urandom_range(0, 3);
    return s ? 32'($signed(v << k) >>> k) : v >> k;
  endfunction : rnd
  task automatic do_op(mdu_op_type op, logic s, logic [31:0] a, b);
    mdu_req_type r;
    logic [63:0] p;
    int n;
    r = '{op, s, 5'($urandom), a, b};
    p = mul64(a, b, s);
    n = 0;
    u_iss.issue(r, w);
    u_iss.drop_req();
    if (op == MDU_OP_MULGPR) begin
      while (gpr_wb.valid !== 1'b1 && n < 6) begin
        tick(1);
        n++;
      end
      check(64'(n), fits16(b, s) ? 64'h1 : 64'h2);
      check({gpr_wb.dest, gpr_wb.data}, {r.dest, p[31:0]});
      acc_ok = 1'b0;
    end else if (op == MDU_OP_DIV) begin
      while (div_busy === 1'b1 && n < 40) begin
        tick(1);
        n++;
      end
      acc = s ? {32'($signed(a) % $signed(b)), 32'($signed(a) / $signed(b))}
              : {a % b, a / b};
      check({upper, bottom}, acc);
      acc_ok = 1'b1;
    end else begin
      if (!fits16(b, s)) tick(1);
      acc = op == MDU_OP_MADD ? acc + p : op == MDU_OP_MSUB ? acc - p : p;
      check({upper, bottom}, acc);
      acc_ok = 1'b1;
    end
    tick(1);
  endtask : do_op
  initial begin
    void'($urandom(32'h024A22DF));
    acc_ok = 1'b0;
    tick(3);
    sys_rst = 1'b0;
    tick(1);
    u_iss.issue('{MDU_OP_MULT, 1'b0, 5'h0, 32'h12345678, 32'h9ABCDEF0}, w);
    u_iss.issue('{MDU_OP_MULT, 1'b0, 5'h0, 32'h0FEDCBA9, 32'h80000001}, w);
    u_iss.drop_req();
    check(64'(w), 64'h1);
    tick(1);
    check({upper, bottom}, mul64(32'h0FEDCBA9, 32'h80000001, 1'b0));
    u_iss.issue('{MDU_OP_MULT, 1'b1, 5'h0, 32'hFFFFFFFF, 32'h00007FFF}, w);
    u_iss.issue('{MDU_OP_MULT, 1'b1, 5'h0, 32'h80000000, 32'hFFFF8000}, w);
    u_iss.drop_req();
    check(64'(w), 64'h0);
    check({upper, bottom}, mul64(32'h80000000, 32'hFFFF8000, 1'b1));
    u_iss.issue('{MDU_OP_DIV, 1'b0, 5'h0, 32'h000000FF, 32'h00000007}, w);
    u_iss.issue('{MDU_OP_MULT, 1'b0, 5'h0, 32'h00000003, 32'h00000005}, w);
    u_iss.drop_req();
    check(64'(w > 7), 64'h1);
    check({upper, bottom}, 64'hF);
    tick(1);
    for (int i = 0; i < 8; i++) begin
      do_op(MDU_OP_DIV, 1'(i % 2), (i % 2) ? 32'hFFFFFFFF << (8 * (i / 2) + 7)
        : 32'hFFFFFFFF >> (24 - 8 * (i / 2)), 32'($urandom_range(1, 200)));
    end
    for (int i = 0; i < 60; i++) begin
      mdu_op_type op;
      logic s;
      logic [31:0] b;
      op = mdu_op_type'($urandom_range(1, 5));
      s = 1'($urandom);
      if (!acc_ok && op inside {MDU_OP_MADD, MDU_OP_MSUB}) op = MDU_OP_MULT;
      b = rnd(s);
      if (op == MDU_OP_DIV && (b == 32'h0 || b == 32'hFFFFFFFF)) b = 32'h5;
      do_op(op, s, rnd(s), b);
    end
    u_iss.issue('{MDU_OP_DIV, 1'b1, 5'h0, 32'h7FFFFFFF, 32'h00000003}, w);
    u_iss.drop_req();
    tick(3);
    sys_rst = 1'b1;
    tick(2);
    check({upper, bottom}, 64'h0);
    check({div_busy, gpr_wb.valid}, 64'h0);
    sys_rst = 1'b0;
    acc_ok = 1'b0;
    tick(1);
    do_op(MDU_OP_MULGPR, 1'b0, 32'hFFFFFFFF, 32'hFFFFFFFF);
    final_report();
  end
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule : testbench
bind mdu_unit mdu_monitor u_mon (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .req_valid(req_valid), .req(req), .pipe_stall(pipe_stall), .stall(stall),
  .result_upper_word(result_upper_word),
  .result_bottom_word(result_bottom_word), .gpr_wb(gpr_wb),
  .div_busy(div_busy));
`default_nettype wire
